/* hw/setup_ctrl_pkg.sv */
// Constants, types and register map of the default-mode setup control
package setup_ctrl_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned PRST_NS         = 1000;
  localparam int unsigned PRST_CYCLES     = (PRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DB_W            = 20;
  localparam int unsigned PRST_W          = 6;
  // Storage geometry
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned MEM_AW    = 1;
  localparam int unsigned MEM_DEPTH = 2;
  localparam int unsigned APB_AW    = 12;
  // Characters
  localparam logic [7:0] CHAR_NUL    = 8'h00;
  localparam logic [7:0] CHAR_CR     = 8'h0d;
  localparam logic [7:0] CHAR_DOLLAR = 8'h24;
  localparam logic [7:0] CHAR_HASH   = 8'h23;
  localparam logic [7:0] CHAR_LBRACE = 8'h7b;
  localparam logic [7:0] CHAR_RBRACE = 8'h7d;
  // Setup word fields
  localparam int unsigned ADDR_LSB = 0;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned BAUD_LSB = 8;
  localparam int unsigned BAUD_W   = 4;
  localparam int unsigned PAR_LSB  = 12;
  localparam int unsigned PAR_W    = 2;
  localparam logic [BAUD_W-1:0] BAUD_300    = 4'h0;
  localparam logic [PAR_W-1:0]  PARITY_NONE = 2'h0;
  localparam logic [WORD_W-1:0] SETUP_RESET  = 16'h0031;
  localparam logic [WORD_W-1:0] TIMING_RESET = 16'h0000;
  // Register map
  localparam logic [APB_AW-1:0] OFS_SETUP  = 12'h000;
  localparam logic [APB_AW-1:0] OFS_TIMING = 12'h004;
  localparam logic [APB_AW-1:0] OFS_STATUS = 12'h008;
  localparam logic [1:0] SEL_SETUP  = 2'h0;
  localparam logic [1:0] SEL_TIMING = 2'h1;
  localparam logic [1:0] SEL_STATUS = 2'h2;
  localparam logic [1:0] SEL_NONE   = 2'h3;
  localparam int unsigned ST_FORCED_BIT = 0;
  localparam int unsigned ST_RUN_BIT    = 1;
  localparam int unsigned ST_XMIT_BIT   = 2;
  localparam int unsigned ST_BAUD_LSB   = 4;
  localparam int unsigned ST_PAR_LSB    = 8;

  typedef enum logic [1:0] {
    FSM_BOOT = 2'b00,
    FSM_LOAD = 2'b01,
    FSM_RUN  = 2'b11,
    FSM_PRST = 2'b10
  } fsm_type;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic              re;
    logic              we;
    logic [MEM_AW-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mem_req_type;
endpackage : setup_ctrl_pkg

/* hw/setup_store.sv */
// Small setup storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module setup_store (
  input  wire logic                                clk_in,
  input  wire logic                                sys_rst_in,
  input  wire logic                                ce_in,
  input  wire setup_ctrl_pkg::mem_req_type         req_in,
  output logic [setup_ctrl_pkg::WORD_W-1:0]        rdata_out
);
  typedef struct packed {
    logic [setup_ctrl_pkg::MEM_DEPTH-1:0][setup_ctrl_pkg::WORD_W-1:0] mem;
    logic [setup_ctrl_pkg::WORD_W-1:0]                                rdata;
  } store_type;

  store_type store_reg;
  store_type store_next;

  // Write port and registered read port
  always_comb begin
    store_next = store_reg;
    if (ce_in) begin
      if (req_in.we) begin
        store_next.mem[req_in.addr] = req_in.wdata;
      end
      if (req_in.re) begin
        store_next.rdata = store_reg.mem[req_in.addr];
      end
    end
  end

  // Factory contents after reset
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      store_reg.mem[0] <= setup_ctrl_pkg::SETUP_RESET;
      store_reg.mem[1] <= setup_ctrl_pkg::TIMING_RESET;
      store_reg.rdata  <= '0;
    end else begin
      store_reg <= store_next;
    end
  end

  assign rdata_out = store_reg.rdata;
endmodule : setup_store
`default_nettype wire

/* hw/default_mode_setup_control.sv */
// Setup selection, forced default mode and reply gating with APB access
//
// Contract
// R1: Strap grounded gives 300 baud, no parity, and any stored address ignored.
// R2: Forced default never writes setup storage; only active parameters are overridden.
// R3: Forced default accepts any address except NUL, CR, $, #, { and }.
// R4: Host always sends an address character in forced default commands.
// R5: Strap release causes program reset, then stored baud and parity apply.
// R6: Setup writes change storage only; forced default values stay fixed.
// R7: Host ends commands with carriage return and sends upper-case mnemonics.
// R8: Every reply ends with a carriage return.
// R9: Stored setup reads back, also while forced default is active.
// R10: Only a matched unit replies, transmitter on for reply then off.
// R11: At power-up load setup from storage before communicating.
// R12: Strap is synchronised and debounced; one transition gives one mode change.
`timescale 1ns/100ps
`default_nettype none
module default_mode_setup_control #(
  parameter int unsigned DEBOUNCE_CYCLES = setup_ctrl_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic                               clk_in,
  input  wire logic                               sys_rst_in,
  input  wire logic                               ce_in,
  input  wire logic                               strap_n_in,
  input  wire setup_ctrl_pkg::apb_req_type        apb_req_in,
  output setup_ctrl_pkg::apb_rsp_type             apb_rsp_out,
  input  wire logic                               addr_valid_in,
  input  wire logic [7:0]                         addr_char_in,
  input  wire logic                               reply_valid_in,
  input  wire logic [7:0]                         reply_byte_in,
  input  wire logic                               reply_last_in,
  output logic                                    reply_ready_out,
  output logic                                    tx_valid_out,
  output logic [7:0]                              tx_byte_out,
  input  wire logic                               tx_ready_in,
  output logic                                    xmit_on_out,
  output logic                                    match_out,
  output logic [setup_ctrl_pkg::BAUD_W-1:0]       baud_out,
  output logic [setup_ctrl_pkg::PAR_W-1:0]        parity_out,
  output logic [setup_ctrl_pkg::WORD_W-1:0]       timing_out,
  output logic                                    forced_default_out,
  output logic                                    prog_reset_out,
  output logic                                    comm_ready_out
);
  typedef struct packed {
    setup_ctrl_pkg::fsm_type                 fsm;
    logic                                    load_idx;
    logic                                    sync1;
    logic                                    sync2;
    logic                                    db_level;
    logic [setup_ctrl_pkg::DB_W-1:0]         db_cnt;
    logic [setup_ctrl_pkg::PRST_W-1:0]       prst_cnt;
    logic [setup_ctrl_pkg::WORD_W-1:0]       setup_word;
    logic [setup_ctrl_pkg::WORD_W-1:0]       timing_word;
    logic [setup_ctrl_pkg::BAUD_W-1:0]       baud;
    logic [setup_ctrl_pkg::PAR_W-1:0]        parity;
    logic                                    rd_busy;
    logic                                    rd_valid;
    logic [1:0]                              rd_sel;
    logic [31:0]                             prdata;
    logic                                    match;
    logic                                    xmit_on;
    logic                                    tx_valid;
    logic [7:0]                              tx_byte;
    logic                                    cr_pending;
    logic                                    cr_out;
  } ctrl_type;

  ctrl_type                                ctrl_reg;
  ctrl_type                                ctrl_next;
  setup_ctrl_pkg::mem_req_type             mem_req;
  logic [setup_ctrl_pkg::WORD_W-1:0]       mem_rdata;
  logic                                    run;
  logic                                    forced_next;
  logic [1:0]                              sel;
  logic                                    slot_free;

  // Register select from an APB address
  function automatic logic [1:0] reg_sel(input logic [setup_ctrl_pkg::APB_AW-1:0] addr);
    if (addr == setup_ctrl_pkg::OFS_SETUP) begin
      reg_sel = setup_ctrl_pkg::SEL_SETUP;
    end else if (addr == setup_ctrl_pkg::OFS_TIMING) begin
      reg_sel = setup_ctrl_pkg::SEL_TIMING;
    end else if (addr == setup_ctrl_pkg::OFS_STATUS) begin
      reg_sel = setup_ctrl_pkg::SEL_STATUS;
    end else begin
      reg_sel = setup_ctrl_pkg::SEL_NONE;
    end
  endfunction : reg_sel

  // Characters that can never be an address
  function automatic logic is_reserved(input logic [7:0] c);
    is_reserved = (c == setup_ctrl_pkg::CHAR_NUL) || (c == setup_ctrl_pkg::CHAR_CR) ||
                  (c == setup_ctrl_pkg::CHAR_DOLLAR) || (c == setup_ctrl_pkg::CHAR_HASH) ||
                  (c == setup_ctrl_pkg::CHAR_LBRACE) || (c == setup_ctrl_pkg::CHAR_RBRACE);
  endfunction : is_reserved

  setup_store u_store (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .req_in     (mem_req),
    .rdata_out  (mem_rdata)
  );

  assign run       = (ctrl_reg.fsm == setup_ctrl_pkg::FSM_RUN);
  assign sel       = reg_sel(apb_req_in.paddr);
  assign slot_free = !ctrl_reg.tx_valid || tx_ready_in;

  // Next state of the whole block
  always_comb begin
    ctrl_next   = ctrl_reg;
    mem_req     = '0;
    forced_next = !ctrl_reg.db_level;
    if (ce_in) begin
      // Strap synchroniser and debounce
      ctrl_next.sync1 = strap_n_in;
      ctrl_next.sync2 = ctrl_reg.sync1;
      if (ctrl_reg.sync2 != ctrl_reg.db_level) begin // see R12
        if (ctrl_reg.db_cnt == setup_ctrl_pkg::DB_W'(DEBOUNCE_CYCLES - 1)) begin
          ctrl_next.db_level = ctrl_reg.sync2;
          ctrl_next.db_cnt   = '0;
        end else begin
          ctrl_next.db_cnt = ctrl_reg.db_cnt + 1'b1;
        end
      end else begin
        ctrl_next.db_cnt = '0;
      end
      forced_next = !ctrl_next.db_level;
      // Boot, load and program reset sequence
      case (ctrl_reg.fsm)
        setup_ctrl_pkg::FSM_BOOT: begin
          mem_req.re         = 1'b1; // see R11
          mem_req.addr       = '0;
          ctrl_next.load_idx = 1'b0;
          ctrl_next.fsm      = setup_ctrl_pkg::FSM_LOAD;
        end
        setup_ctrl_pkg::FSM_LOAD: begin
          if (!ctrl_reg.load_idx) begin
            ctrl_next.setup_word = mem_rdata; // see R5
            mem_req.re           = 1'b1;
            mem_req.addr         = 1'b1;
            ctrl_next.load_idx   = 1'b1;
          end else begin
            ctrl_next.timing_word = mem_rdata;
            ctrl_next.fsm         = setup_ctrl_pkg::FSM_RUN;
          end
        end
        setup_ctrl_pkg::FSM_RUN: begin
          if (ctrl_reg.db_level == 1'b0 && ctrl_next.db_level == 1'b1) begin // see R5
            ctrl_next.fsm      = setup_ctrl_pkg::FSM_PRST;
            ctrl_next.prst_cnt = '0;
            ctrl_next.xmit_on  = 1'b0;
            ctrl_next.tx_valid = 1'b0;
            ctrl_next.cr_pending = 1'b0;
            ctrl_next.cr_out   = 1'b0;
          end
        end
        default: begin
          ctrl_next.prst_cnt = ctrl_reg.prst_cnt + 1'b1;
          if (ctrl_reg.prst_cnt == setup_ctrl_pkg::PRST_W'(setup_ctrl_pkg::PRST_CYCLES - 1)) begin
            ctrl_next.fsm = setup_ctrl_pkg::FSM_BOOT;
          end
        end
      endcase
      // Active parameters, stored values untouched while forced
      if (forced_next) begin // see R1
        ctrl_next.baud   = setup_ctrl_pkg::BAUD_300;
        ctrl_next.parity = setup_ctrl_pkg::PARITY_NONE;
      end else begin
        ctrl_next.baud   = ctrl_next.setup_word[setup_ctrl_pkg::BAUD_LSB +: setup_ctrl_pkg::BAUD_W];
        ctrl_next.parity = ctrl_next.setup_word[setup_ctrl_pkg::PAR_LSB +: setup_ctrl_pkg::PAR_W];
      end
      // APB writes go to storage only
      if (apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && run &&
          (sel == setup_ctrl_pkg::SEL_SETUP || sel == setup_ctrl_pkg::SEL_TIMING)) begin
        mem_req.we    = 1'b1; // see R2, R6
        mem_req.addr  = sel[0];
        mem_req.wdata = apb_req_in.pwdata[setup_ctrl_pkg::WORD_W-1:0];
      end
      // APB read launch, capture and release
      if (apb_req_in.psel && !apb_req_in.pwrite && !ctrl_reg.rd_busy && run) begin
        ctrl_next.rd_busy = 1'b1;
        ctrl_next.rd_sel  = sel;
        if (sel == setup_ctrl_pkg::SEL_SETUP || sel == setup_ctrl_pkg::SEL_TIMING) begin
          mem_req.re   = 1'b1; // see R9
          mem_req.addr = sel[0];
        end
      end
      if (ctrl_reg.rd_busy && !ctrl_reg.rd_valid) begin
        ctrl_next.rd_valid = 1'b1;
        ctrl_next.prdata   = '0;
        if (ctrl_reg.rd_sel == setup_ctrl_pkg::SEL_STATUS) begin
          ctrl_next.prdata[setup_ctrl_pkg::ST_FORCED_BIT] = !ctrl_reg.db_level;
          ctrl_next.prdata[setup_ctrl_pkg::ST_RUN_BIT]    = run;
          ctrl_next.prdata[setup_ctrl_pkg::ST_XMIT_BIT]   = ctrl_reg.xmit_on;
          ctrl_next.prdata[setup_ctrl_pkg::ST_BAUD_LSB +: setup_ctrl_pkg::BAUD_W] = ctrl_reg.baud;
          ctrl_next.prdata[setup_ctrl_pkg::ST_PAR_LSB +: setup_ctrl_pkg::PAR_W]   = ctrl_reg.parity;
        end else if (ctrl_reg.rd_sel != setup_ctrl_pkg::SEL_NONE) begin
          ctrl_next.prdata[setup_ctrl_pkg::WORD_W-1:0] = mem_rdata;
        end
      end
      if (apb_req_in.psel && apb_req_in.penable && apb_rsp_out.pready) begin
        ctrl_next.rd_busy  = 1'b0;
        ctrl_next.rd_valid = 1'b0;
      end
      // Address match, forced mode accepts any legal character
      ctrl_next.match = 1'b0;
      if (addr_valid_in && run) begin
        if (!ctrl_reg.db_level) begin
          ctrl_next.match = !is_reserved(addr_char_in); // see R3
        end else begin
          ctrl_next.match = (addr_char_in == ctrl_reg.setup_word[setup_ctrl_pkg::ADDR_LSB +: setup_ctrl_pkg::ADDR_W]);
        end
      end
      if (ctrl_reg.match && !ctrl_reg.xmit_on && run) begin
        ctrl_next.xmit_on = 1'b1; // see R10
      end
      // Reply byte stream with appended carriage return
      if (ctrl_reg.tx_valid && tx_ready_in) begin
        ctrl_next.tx_valid = 1'b0;
        if (ctrl_reg.cr_out) begin
          ctrl_next.cr_out  = 1'b0;
          ctrl_next.xmit_on = 1'b0; // see R10
        end
      end
      if (reply_valid_in && reply_ready_out) begin
        ctrl_next.tx_valid   = 1'b1;
        ctrl_next.tx_byte    = reply_byte_in;
        ctrl_next.cr_pending = reply_last_in;
      end else if (ctrl_reg.cr_pending && slot_free) begin
        ctrl_next.tx_valid   = 1'b1; // see R8
        ctrl_next.tx_byte    = setup_ctrl_pkg::CHAR_CR;
        ctrl_next.cr_pending = 1'b0;
        ctrl_next.cr_out     = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_reg          <= '0;
      ctrl_reg.fsm      <= setup_ctrl_pkg::FSM_BOOT;
      ctrl_reg.sync1    <= 1'b1;
      ctrl_reg.sync2    <= 1'b1;
      ctrl_reg.db_level <= 1'b1;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Outputs
  assign reply_ready_out    = ctrl_reg.xmit_on && !ctrl_reg.cr_pending && !ctrl_reg.cr_out && slot_free && run;
  assign tx_valid_out       = ctrl_reg.tx_valid;
  assign tx_byte_out        = ctrl_reg.tx_byte;
  assign xmit_on_out        = ctrl_reg.xmit_on;
  assign match_out          = ctrl_reg.match;
  assign baud_out           = ctrl_reg.baud;
  assign parity_out         = ctrl_reg.parity;
  assign timing_out         = ctrl_reg.timing_word;
  assign forced_default_out = !ctrl_reg.db_level;
  assign prog_reset_out     = (ctrl_reg.fsm == setup_ctrl_pkg::FSM_PRST);
  assign comm_ready_out     = run;
  assign apb_rsp_out.prdata = ctrl_reg.prdata;
  assign apb_rsp_out.pready = apb_req_in.penable && (apb_req_in.pwrite ? run : ctrl_reg.rd_valid);
  assign apb_rsp_out.pslverr = apb_req_in.penable && apb_rsp_out.pready &&
                               (sel == setup_ctrl_pkg::SEL_NONE ||
                                (apb_req_in.pwrite && sel == setup_ctrl_pkg::SEL_STATUS));

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  localparam int PRST_MAX = 40;

  property p_forced_params;
    forced_default_out |-> (baud_out == setup_ctrl_pkg::BAUD_300) && (parity_out == setup_ctrl_pkg::PARITY_NONE);
  endproperty
  a_forced_params: assert property (p_forced_params) else $error("forced mode parameters wrong"); // see R1
  property p_store_write_only_apb;
    mem_req.we |-> apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && run;
  endproperty
  a_store_write_only_apb: assert property (p_store_write_only_apb) else $error("storage written outside APB write"); // see R2
  property p_reserved_rejected;
    (addr_valid_in && ce_in && forced_default_out && run && is_reserved(addr_char_in)) |=> !match_out;
  endproperty
  a_reserved_rejected: assert property (p_reserved_rejected) else $error("reserved address accepted"); // see R3
  property p_any_accepted;
    (addr_valid_in && ce_in && forced_default_out && run && !is_reserved(addr_char_in)) |=> match_out;
  endproperty
  a_any_accepted: assert property (p_any_accepted) else $error("legal address not accepted"); // see R3
  property p_release_reset;
    ($fell(forced_default_out) && $past(run)) |-> prog_reset_out ##[1:PRST_MAX] comm_ready_out;
  endproperty
  a_release_reset: assert property (p_release_reset) else $error("no program reset on release"); // see R5
  property p_cr_before_off;
    $fell(xmit_on_out) && !prog_reset_out |-> $past(tx_valid_out && tx_ready_in && tx_byte_out == setup_ctrl_pkg::CHAR_CR);
  endproperty
  a_cr_before_off: assert property (p_cr_before_off) else $error("transmitter off without CR"); // see R8
  property p_read_answer;
    (apb_req_in.psel && !apb_req_in.penable && !apb_req_in.pwrite && run && ce_in) ##1 ce_in |-> ##1 apb_rsp_out.pready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("setup read not answered"); // see R9
  property p_tx_needs_match;
    tx_valid_out |-> xmit_on_out;
  endproperty
  a_tx_needs_match: assert property (p_tx_needs_match) else $error("reply while transmitter off"); // see R10
  property p_boot_load;
    $rose(comm_ready_out) |-> $past(ctrl_reg.fsm == setup_ctrl_pkg::FSM_LOAD);
  endproperty
  a_boot_load: assert property (p_boot_load) else $error("run without load"); // see R11
  property p_debounce;
    $changed(forced_default_out) |-> $past(ctrl_reg.db_cnt) == setup_ctrl_pkg::DB_W'(DEBOUNCE_CYCLES - 1);
  endproperty
  a_debounce: assert property (p_debounce) else $error("strap change without debounce"); // see R12

  c_forced: cover property ($rose(forced_default_out));
  c_release: cover property ($rose(prog_reset_out));
  c_reply_cr: cover property (tx_valid_out && tx_ready_in && tx_byte_out == setup_ctrl_pkg::CHAR_CR);
  c_apb_read: cover property (apb_req_in.penable && !apb_req_in.pwrite && apb_rsp_out.pready);
endmodule : default_mode_setup_control
`default_nettype wire

/* verification/host_side_model.sv */
// Host-side model: sends address characters and collects reply bytes
`timescale 1ns/100ps
`default_nettype none
module host_side_model (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_byte_in,
  output logic            tx_ready_out,
  output logic            addr_valid_out,
  output logic [7:0]      addr_char_out
);
  logic [7:0] rx_q[$];
  initial begin
    addr_valid_out = 1'b0;
    addr_char_out = 8'h00;
  end
  // Sink with random stalls; keeps every accepted byte
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_ready_out <= 1'b0;
    end else begin
      if (tx_valid_in && tx_ready_out) begin
        rx_q.push_back(tx_byte_in);
      end
      tx_ready_out <= 1'($urandom_range(0, 1));
    end
  end
  // One address character opens every command
  // Commands stand for upper-case, CR-ended frames
  task automatic send_addr(input logic [7:0] c);
    @(posedge clk_in);
    addr_char_out <= c;
    addr_valid_out <= 1'b1;
    @(posedge clk_in);
    addr_valid_out <= 1'b0;
  endtask : send_addr
endmodule : host_side_model
`default_nettype wire

/* verification/tb_default_mode_setup_control.sv */
// Self-checking bench of the default-mode setup control
`timescale 1ns/100ps
`default_nettype none
module tb_default_mode_setup_control;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic strap_n_in = 1'b1;
  logic reply_valid_in = 1'b0;
  logic reply_last_in = 1'b0;
  logic [7:0] reply_byte_in = 8'h00;
  setup_ctrl_pkg::apb_req_type req = '0;
  setup_ctrl_pkg::apb_rsp_type rsp;
  logic tx_valid_out, tx_ready_in, addr_valid_in, xmit_on_out, match_out, reply_ready_out;
  logic forced_default_out, prog_reset_out, comm_ready_out, err, seen;
  logic ce = 1'b1;
  logic [7:0] tx_byte_out, addr_char_in;
  logic [3:0] baud_out;
  logic [1:0] parity_out;
  logic [15:0] timing_out;
  logic [31:0] rd, w, tm;
  logic [7:0] resv[6] = '{8'h00, 8'h0d, 8'h24, 8'h23, 8'h7b, 8'h7d};
  int failures = 0, num_checks = 0, cycles = 0, act = 32'h31;

  default_mode_setup_control #(.DEBOUNCE_CYCLES(4)) i_default_mode_setup_control (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce), .strap_n_in(strap_n_in),
    .apb_req_in(req), .apb_rsp_out(rsp), .addr_valid_in(addr_valid_in), .addr_char_in(addr_char_in),
    .reply_valid_in(reply_valid_in), .reply_byte_in(reply_byte_in), .reply_last_in(reply_last_in),
    .reply_ready_out(reply_ready_out), .tx_valid_out(tx_valid_out), .tx_byte_out(tx_byte_out),
    .tx_ready_in(tx_ready_in), .xmit_on_out(xmit_on_out), .match_out(match_out), .baud_out(baud_out),
    .parity_out(parity_out), .timing_out(timing_out), .forced_default_out(forced_default_out),
    .prog_reset_out(prog_reset_out), .comm_ready_out(comm_ready_out));

  host_side_model i_host_side_model (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .tx_valid_in(tx_valid_out), .tx_byte_in(tx_byte_out),
    .tx_ready_out(tx_ready_in), .addr_valid_out(addr_valid_in), .addr_char_out(addr_char_in));

  // Clock and hang limit
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_in);
    req.penable <= 1'b1;
    do @(posedge clk_in); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb

  // One-byte reply, then the appended end byte
  task automatic serve(input logic [7:0] b);
    i_host_side_model.rx_q.delete();
    @(posedge clk_in);
    reply_byte_in <= b;
    reply_valid_in <= 1'b1;
    reply_last_in <= 1'b1;
    do @(posedge clk_in); while (reply_ready_out !== 1'b1);
    reply_valid_in <= 1'b0;
    reply_last_in <= 1'b0;
    for (int i = 0; i < 60 && xmit_on_out !== 1'b0; i++) @(negedge clk_in);
    check(xmit_on_out, 0);
    check(i_host_side_model.rx_q.size(), 2);
    check({i_host_side_model.rx_q[0], i_host_side_model.rx_q[1]}, {b, 8'h0d});
  endtask : serve

  task automatic addr(input logic [7:0] c, input logic m);
    i_host_side_model.send_addr(c);
    #1;
    check(match_out, m);
  endtask : addr

  initial begin
    void'($urandom(32'h80c7));
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 20 && comm_ready_out !== 1'b1; i++) @(negedge clk_in);
    check(comm_ready_out, 1);
    check({parity_out, baud_out}, (act >> 8) & 32'h3f);
    apb(1'b0, setup_ctrl_pkg::OFS_SETUP, 0);
    check(rd, act);
    addr(8'h31, 1'b1);
    serve(8'($urandom_range(0, 255)));
    addr(8'h32, 1'b0);
    check(xmit_on_out, 0);
    w = ($urandom_range(1, 2) << 12) | ($urandom_range(1, 7) << 8) | $urandom_range(65, 90);
    tm = $urandom_range(1, 65535);
    apb(1'b1, setup_ctrl_pkg::OFS_SETUP, w);
    apb(1'b1, setup_ctrl_pkg::OFS_TIMING, tm);
    apb(1'b0, setup_ctrl_pkg::OFS_SETUP, 0);
    check(rd, w);
    apb(1'b0, 12'h00c, 0);
    check(err, 1);
    check(rd, 0);
    apb(1'b1, setup_ctrl_pkg::OFS_STATUS, 32'hffff);
    check(err, 1);
    apb(1'b0, setup_ctrl_pkg::OFS_STATUS, 0);
    check(rd, (((act >> 8) & 15) << 4) | (((act >> 12) & 3) << 8) | 2);
    // Clock enable low freezes the strap path
    @(posedge clk_in);
    ce <= 1'b0;
    strap_n_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    strap_n_in <= 1'b1;
    @(posedge clk_in);
    ce <= 1'b1;
    repeat (8) @(negedge clk_in);
    check(forced_default_out, 0);
    check(comm_ready_out, 1);
    // Short strap glitch must be ignored
    @(posedge clk_in);
    strap_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    strap_n_in <= 1'b1;
    seen = 1'b0;
    repeat (12) @(negedge clk_in) seen |= forced_default_out;
    check(seen, 0);
    @(posedge clk_in);
    strap_n_in <= 1'b0;
    for (int i = 0; i < 30 && forced_default_out !== 1'b1; i++) @(negedge clk_in);
    check(forced_default_out, 1);
    check({parity_out, baud_out}, 0);
    apb(1'b0, setup_ctrl_pkg::OFS_SETUP, 0);
    check(rd, w);
    foreach (resv[k]) addr(resv[k], 1'b0);
    addr(8'h3f, 1'b1);
    serve(8'($urandom_range(0, 255)));
    w = ($urandom_range(1, 2) << 12) | ($urandom_range(8, 15) << 8) | $urandom_range(65, 90);
    apb(1'b1, setup_ctrl_pkg::OFS_SETUP, w);
    check({parity_out, baud_out}, 0);
    @(posedge clk_in);
    strap_n_in <= 1'b1;
    for (int i = 0; i < 30 && prog_reset_out !== 1'b1; i++) @(negedge clk_in);
    check(prog_reset_out, 1);
    for (int i = 0; i < 60 && comm_ready_out !== 1'b1; i++) @(negedge clk_in);
    act = w;
    check({forced_default_out, parity_out, baud_out}, (act >> 8) & 32'h3f);
    check(timing_out, tm);
    addr(w[7:0], 1'b1);
    serve(8'h2a);
    stop_test();
  end
endmodule : tb_default_mode_setup_control
`default_nettype wire
